/* logic/posm_defines.vh */
/*
  Constants for the output pin select map: register offsets, field positions,
  reset values and bus answer codes.
  Assumes it is included by bare name from the design files under logic/.
*/
// How it works
// - A field holding n from 1 to 31 routes peripheral output n to its pin; zero leaves the pin to port control.
// - Bits 4 to 0 of each register select for the even pin.
// - Bits 12 to 8 of each register select for the odd pin.
// - Bits 15 to 13 ignore writes and read as zero.
// - Bits 7 to 5 ignore writes and read as zero.
// - Reset clears every selection field to zero.
// - Selection fields are writable and read back the last written value.
// - Eight registers, register k controls pins 2k and 2k+1.
`ifndef POSM_DEFINES_VH
`define POSM_DEFINES_VH

// ==========================================================
// Register map
`define POSM_REG_COUNT 8
`define POSM_PIN_COUNT 16
`define POSM_PERIPH_COUNT 32
`define POSM_OFS_SEL_0_1 8'h00
`define POSM_OFS_SEL_2_3 8'h04
`define POSM_OFS_SEL_4_5 8'h08
`define POSM_OFS_SEL_6_7 8'h0c
`define POSM_OFS_SEL_8_9 8'h10
`define POSM_OFS_SEL_10_11 8'h14
`define POSM_OFS_SEL_12_13 8'h18
`define POSM_OFS_SEL_14_15 8'h1c
`define POSM_ADDR_W 8

// ==========================================================
// Field layout
`define POSM_SEL_W 5
`define POSM_EVEN_LSB 0
`define POSM_ODD_LSB 8
`define POSM_FIELD_RESET 5'h00
`define POSM_SEL_NONE 5'h00

// ==========================================================
// Bus answers
`define POSM_RESP_OKAY 2'h0
`define POSM_RESP_SLVERR 2'h2

`endif

/* logic/posm_axil_slave.v */
/*
  AXI4-Lite slave front end: accepts one write and one read at a time and
  hands single-cycle strobes to the register file.
  Assumes a master that keeps valid and payload stable until taken.
*/
`timescale 1ns/100ps
`default_nettype none
`include "posm_defines.vh"

module posm_axil_slave (
  input wire core_clk_in,
  input wire rstn_in,
  input wire [`POSM_ADDR_W-1:0] awaddr_in,
  input wire awvalid_in,
  output reg awready_out,
  input wire [31:0] wdata_in,
  input wire [3:0] wstrb_in,
  input wire wvalid_in,
  output reg wready_out,
  output reg [1:0] bresp_out,
  output reg bvalid_out,
  input wire bready_in,
  input wire [`POSM_ADDR_W-1:0] araddr_in,
  input wire arvalid_in,
  output reg arready_out,
  output reg [31:0] rdata_out,
  output reg [1:0] rresp_out,
  output reg rvalid_out,
  input wire rready_in,
  output reg wr_stb_out,
  output reg [`POSM_ADDR_W-1:0] wr_addr_out,
  output reg [31:0] wr_data_out,
  output reg [3:0] wr_strb_out,
  input wire wr_ok_in,
  output reg rd_stb_out,
  output reg [`POSM_ADDR_W-1:0] rd_addr_out,
  input wire [31:0] rd_data_in,
  input wire rd_ok_in
);

  reg aw_held;
  reg w_held;
  reg wr_pend;
  reg rd_pend;

  // ==========================================================
  // Write path: address and data are latched in either order
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_stb_out <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr_out <= {`POSM_ADDR_W{1'b0}};
      wr_data_out <= 32'h0000_0000;
      wr_strb_out <= 4'h0;
      bvalid_out <= 1'b0;
      bresp_out <= `POSM_RESP_OKAY;
    end else begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
      wr_stb_out <= 1'b0;
      // Ready is a one-cycle pulse so each item is taken exactly once
      if (awvalid_in && !aw_held && !awready_out && !bvalid_out) begin
        awready_out <= 1'b1;
        aw_held <= 1'b1;
        wr_addr_out <= awaddr_in;
      end
      if (wvalid_in && !w_held && !wready_out && !bvalid_out) begin
        wready_out <= 1'b1;
        w_held <= 1'b1;
        wr_data_out <= wdata_in;
        wr_strb_out <= wstrb_in;
      end
      if (aw_held && w_held && !wr_pend) begin
        wr_stb_out <= 1'b1;
        wr_pend <= 1'b1;
      end
      // Response one cycle after the strobe, once decode has answered
      if (wr_stb_out) begin
        bvalid_out <= 1'b1;
        bresp_out <= wr_ok_in ? `POSM_RESP_OKAY : `POSM_RESP_SLVERR;
      end
      if (bvalid_out && bready_in) begin
        bvalid_out <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        wr_pend <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Read path
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      arready_out <= 1'b0;
      rd_stb_out <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr_out <= {`POSM_ADDR_W{1'b0}};
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= `POSM_RESP_OKAY;
    end else begin
      arready_out <= 1'b0;
      rd_stb_out <= 1'b0;
      if (arvalid_in && !rd_pend && !arready_out) begin
        arready_out <= 1'b1;
        rd_pend <= 1'b1;
        rd_stb_out <= 1'b1;
        rd_addr_out <= araddr_in;
      end
      if (rd_stb_out) begin
        rvalid_out <= 1'b1;
        rdata_out <= rd_ok_in ? rd_data_in : 32'h0000_0000;
        rresp_out <= rd_ok_in ? `POSM_RESP_OKAY : `POSM_RESP_SLVERR;
      end
      if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
        rd_pend <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* logic/posm_pin_steer.v */
/*
  Steering for one remappable pin: picks the peripheral output named by its
  selection field and reports whether the pin is taken from port control.
  Assumes the peripheral outputs and port latch are synchronous to the clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "posm_defines.vh"

module posm_pin_steer (
  input wire core_clk_in,
  input wire rstn_in,
  input wire [`POSM_SEL_W-1:0] sel_in,
  input wire [`POSM_PERIPH_COUNT-1:0] periph_out_in,
  input wire [`POSM_PERIPH_COUNT-1:0] periph_oe_in,
  input wire port_out_in,
  input wire port_oe_in,
  output reg pin_out,
  output reg pin_oe_out,
  output reg pin_mapped_out
);

  // ==========================================================
  // Registered mux so pins come straight from flip-flops
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pin_out <= 1'b0;
      pin_oe_out <= 1'b0;
      pin_mapped_out <= 1'b0;
    end else if (sel_in == `POSM_SEL_NONE) begin
      pin_out <= port_out_in;
      pin_oe_out <= port_oe_in;
      pin_mapped_out <= 1'b0;
    end else begin
      pin_out <= periph_out_in[sel_in];
      pin_oe_out <= periph_oe_in[sel_in];
      pin_mapped_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

/* logic/posm_top.v */
/*
  Output pin select map: eight AXI4-Lite registers, two 5-bit selection
  fields each, steering peripheral outputs 1 to 31 onto 16 remappable pins.
  Assumes one 10 MHz clock, synchronous active-low reset, and that
  peripheral output n sits at bit n of the peripheral buses.
*/
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "posm_defines.vh"

module posm_top (
  input wire core_clk_in,
  input wire rstn_in,
  input wire [`POSM_ADDR_W-1:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  output wire [1:0] s_axi_bresp_out,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [`POSM_ADDR_W-1:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [`POSM_PERIPH_COUNT-1:0] periph_out_in,
  input wire [`POSM_PERIPH_COUNT-1:0] periph_oe_in,
  input wire [`POSM_PIN_COUNT-1:0] port_out_in,
  input wire [`POSM_PIN_COUNT-1:0] port_oe_in,
  output wire [`POSM_PIN_COUNT-1:0] pin_out,
  output wire [`POSM_PIN_COUNT-1:0] pin_oe_out,
  output wire [`POSM_PIN_COUNT-1:0] pin_mapped_out
);

  // Selection storage, one entry per pin
  reg [`POSM_SEL_W-1:0] pin_sel [0:`POSM_PIN_COUNT-1];

  wire wr_stb;
  wire [`POSM_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [`POSM_ADDR_W-1:0] rd_addr;
  reg wr_ok;
  reg rd_ok;
  reg [31:0] rd_data;
  wire [2:0] wr_idx;
  wire [2:0] rd_idx;

  // ==========================================================
  // Address decode
  // Word-aligned offsets inside the eight-word window are mapped; anything
  // else answers SLVERR so stray software accesses are visible.
  function addr_hit;
    input [`POSM_ADDR_W-1:0] a;
    begin
      addr_hit = (a[1:0] == 2'b00) && (a[`POSM_ADDR_W-1:5] == 3'b000);
    end
  endfunction

  function [2:0] addr_index;
    input [`POSM_ADDR_W-1:0] a;
    begin
      addr_index = a[4:2];
    end
  endfunction

  assign wr_idx = addr_index(wr_addr);
  assign rd_idx = addr_index(rd_addr);

  // Decode result for the bus slave
  always @* begin
    wr_ok = addr_hit(wr_addr);
    rd_ok = addr_hit(rd_addr);
  end

  // ==========================================================
  // Register read-back: unimplemented bits are forced to zero
  always @* begin
    rd_data = 32'h0000_0000;
    rd_data[`POSM_EVEN_LSB +: `POSM_SEL_W] = pin_sel[{rd_idx, 1'b0}];
    rd_data[`POSM_ODD_LSB +: `POSM_SEL_W] = pin_sel[{rd_idx, 1'b1}];
  end

  // ==========================================================
  // Register writes
  // Byte lane 0 carries the even field and lane 1 the odd one; bits 7-5 and
  // 15-13 are never stored, so writes there are dropped.
  integer i;
  always @(posedge core_clk_in) begin
    if (!rstn_in) begin
      for (i = 0; i < `POSM_PIN_COUNT; i = i + 1) begin
        pin_sel[i] <= `POSM_FIELD_RESET;
      end
    end else if (wr_stb && wr_ok) begin
      if (wr_strb[0]) begin
        pin_sel[{wr_idx, 1'b0}] <= wr_data[`POSM_EVEN_LSB +: `POSM_SEL_W];
      end
      if (wr_strb[1]) begin
        pin_sel[{wr_idx, 1'b1}] <= wr_data[`POSM_ODD_LSB +: `POSM_SEL_W];
      end
    end
  end

  // ==========================================================
  // Bus slave
  posm_axil_slave u_slave (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .awaddr_in(s_axi_awaddr_in),
    .awvalid_in(s_axi_awvalid_in),
    .awready_out(s_axi_awready_out),
    .wdata_in(s_axi_wdata_in),
    .wstrb_in(s_axi_wstrb_in),
    .wvalid_in(s_axi_wvalid_in),
    .wready_out(s_axi_wready_out),
    .bresp_out(s_axi_bresp_out),
    .bvalid_out(s_axi_bvalid_out),
    .bready_in(s_axi_bready_in),
    .araddr_in(s_axi_araddr_in),
    .arvalid_in(s_axi_arvalid_in),
    .arready_out(s_axi_arready_out),
    .rdata_out(s_axi_rdata_out),
    .rresp_out(s_axi_rresp_out),
    .rvalid_out(s_axi_rvalid_out),
    .rready_in(s_axi_rready_in),
    .wr_stb_out(wr_stb),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data),
    .wr_strb_out(wr_strb),
    .wr_ok_in(wr_ok),
    .rd_stb_out(),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_ok_in(rd_ok)
  );

  // ==========================================================
  // One steering cell per pin; pin 2k and 2k+1 share register k
  genvar p;
  generate
    for (p = 0; p < `POSM_PIN_COUNT; p = p + 1) begin : g_pin
      posm_pin_steer u_steer (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .sel_in(pin_sel[p]),
        .periph_out_in(periph_out_in),
        .periph_oe_in(periph_oe_in),
        .port_out_in(port_out_in[p]),
        .port_oe_in(port_oe_in[p]),
        .pin_out(pin_out[p]),
        .pin_oe_out(pin_oe_out[p]),
        .pin_mapped_out(pin_mapped_out[p])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* tb/posm_assertions.sv */
/*
  Checker watching the pin select map top ports.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module posm_assertions (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic [31:0] periph_out_in,
  input wire logic [31:0] periph_oe_in,
  input wire logic [15:0] port_out_in,
  input wire logic [15:0] port_oe_in,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_out,
  input wire logic [15:0] pin_mapped_out
);
  // ==========================================
  // Properties
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  AST_PORT_VAL: assert property ($past(rstn_in) |->
    ((pin_out ^ $past(port_out_in)) & ~pin_mapped_out) == 16'h0000)
    else $error("unmapped pin value wrong");
  AST_PORT_OE: assert property ($past(rstn_in) |->
    ((pin_oe_out ^ $past(port_oe_in)) & ~pin_mapped_out) == 16'h0000)
    else $error("unmapped pin enable wrong");
  // All sources high and disabled makes every mapped pin show it
  AST_ROUTE: assert property ($past(rstn_in) && $past(periph_out_in) == 32'hffff_ffff
    && $past(periph_oe_in) == 32'h0000_0000
    |-> (pin_out & pin_mapped_out) == pin_mapped_out && (pin_oe_out & pin_mapped_out) == 16'h0000)
    else $error("mapped pin not routed");
  AST_RESET: assert property ($rose(rstn_in) |-> pin_mapped_out == 16'h0000
    && !s_axi_bvalid_out && !s_axi_rvalid_out)
    else $error("state not cleared by reset");
  AST_HI_ZERO: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:13] == 19'h0_0000)
    else $error("upper read bits not zero");
  AST_MID_ZERO: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[7:5] == 3'h0)
    else $error("middle read bits not zero");
  AST_WR_RESP: assert property (s_axi_awvalid_in && s_axi_awready_out
    && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:3] s_axi_bvalid_out)
    else $error("write response late");
  AST_RD_RESP: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
  AST_ERR_ZERO: assert property (s_axi_rvalid_out && s_axi_rresp_out == 2'h2
    |-> s_axi_rdata_out == 32'h0000_0000)
    else $error("refused read returned data");
endmodule
bind posm_top posm_assertions posm_assertions_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .periph_out_in(periph_out_in), .periph_oe_in(periph_oe_in),
  .port_out_in(port_out_in), .port_oe_in(port_oe_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
  .pin_mapped_out(pin_mapped_out));
`default_nettype wire

/* tb/posm_periph_model.sv */
/*
  Peripheral outputs and port latch feeding the pin select map.
  Assumes the bench picks counting, fixed or all-high sources.
*/
`timescale 1ns/100ps
`default_nettype none
module posm_periph_model #(
  parameter logic [31:0] PAT = 32'h6c93_5a27
) (
  input wire logic core_clk_in,
  input wire logic [1:0] mode_in,
  output logic [31:0] drive_out,
  output logic [31:0] drive_oe_out,
  output logic [15:0] port_val_out,
  output logic [15:0] port_en_out
);
  logic [31:0] cnt = 32'h0000_0000;
  // ==========================================
  // Sources
  // Odd step flips many bits each cycle, so stale routing shows up
  always @(posedge core_clk_in) begin
    cnt <= cnt + 32'h1357_9bdf;
  end
  assign drive_out = (mode_in == 2'h2) ? 32'hffff_ffff : (mode_in == 2'h1) ? PAT : cnt;
  assign drive_oe_out = ~drive_out;
  assign port_val_out = cnt[31:16];
  assign port_en_out = ~cnt[15:0];
endmodule
`default_nettype wire

/* tb/test_posm_top.sv */
/*
  Bench for the pin select map: register access over AXI4-Lite
  and pin checks. Assumes the peripheral model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
module test_posm_top;
  localparam logic [31:0] PAT = 32'h6c93_5a27;
  logic clk, rstn, aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [7:0] aw_a, ar_a;
  logic [31:0] wd, rd_d, p_o, p_e;
  logic [3:0] ws;
  logic [1:0] b_resp, r_resp, mode;
  logic [15:0] q_o, q_e, pin_o, pin_e, pin_m;
  int err_count = 0, comparisons = 0, cyc = 0, k;
  posm_top posm_top_i (.core_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_rdy), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws), .s_axi_wvalid_in(w_v),
    .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(rd_d),
    .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .periph_out_in(p_o),
    .periph_oe_in(p_e), .port_out_in(q_o), .port_oe_in(q_e), .pin_out(pin_o), .pin_oe_out(pin_e),
    .pin_mapped_out(pin_m));
  posm_periph_model #(.PAT(PAT)) posm_periph_model_i (.core_clk_in(clk), .mode_in(mode), .drive_out(p_o),
    .drive_oe_out(p_e), .port_val_out(q_o), .port_en_out(q_e));
  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  task print_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Valids drop only at the edge that samples their ready
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    aw_a <= a;
    wd <= d;
    ws <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy === 1'b1) aw_v <= 1'b0;
      if (w_rdy === 1'b1) w_v <= 1'b0;
    end while (aw_v || w_v);
    while (b_v !== 1'b1) @(posedge clk);
    b_r <= 1'b0;
    chk({30'h0, b_resp}, {30'h0, r});
    repeat (2) @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do @(posedge clk); while (ar_rdy !== 1'b1);
    ar_v <= 1'b0;
    do @(posedge clk); while (r_v !== 1'b1);
    r_r <= 1'b0;
    chk(rd_d, d);
    chk({30'h0, r_resp}, {30'h0, r});
    @(posedge clk);
  endtask
  // ==========================================
  // Sequence
  initial begin
    {rstn, aw_v, w_v, b_r, ar_v, r_r, aw_a, ar_a, wd, ws, mode} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 8; k++) rd(8'(4 * k), 32'h0, 2'h0);
    for (k = 0; k < 8; k++) begin
      wr(8'(4 * k), 32'hffff_ffff, 4'hf, 2'h0);
      rd(8'(4 * k), 32'h0000_1f1f, 2'h0);
      wr(8'(4 * k), 32'(((2 * k + 2) << 8) | (2 * k + 1)), 4'h3, 2'h0);
    end
    for (k = 0; k < 8; k++) rd(8'(4 * k), 32'(((2 * k + 2) << 8) | (2 * k + 1)), 2'h0);
    mode <= 2'h1;
    repeat (3) @(posedge clk);
    chk({pin_m, pin_o}, {16'hffff, PAT[16:1]});
    chk({16'h0, pin_e}, {16'h0, ~PAT[16:1]});
    // Every source number from 1 to 31 reaches both pins of the first pair
    for (k = 1; k < 32; k++) begin
      wr(8'h00, 32'(((32 - k) << 8) | k), 4'h3, 2'h0);
      chk({pin_e[1:0], pin_o[1:0]}, {~PAT[32 - k], ~PAT[k], PAT[32 - k], PAT[k]});
    end
    mode <= 2'h2;
    repeat (3) @(posedge clk);
    mode <= 2'h1;
    wr(8'h00, 32'h0, 4'h1, 2'h0);
    rd(8'h00, 32'h0000_0100, 2'h0);
    chk({30'h0, pin_m[1:0]}, 32'h0000_0002);
    wr(8'h20, 32'hffff_ffff, 4'hf, 2'h2);
    rd(8'h20, 32'h0, 2'h2);
    rd(8'h02, 32'h0, 2'h2);
    rd(8'h04, 32'h0000_0403, 2'h0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(8'h1c, 32'h0, 2'h0);
    chk({16'h0, pin_m}, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
